// [rtl/asrm_defines.svh]
// Offsets, field positions, key bytes and mode codes of the sensor register bank
`ifndef ASRM_DEFINES_SVH
`define ASRM_DEFINES_SVH
`define ASRM_OFF_IDENT   8'h00
`define ASRM_OFF_REV     8'h01
`define ASRM_OFF_CTRL    8'h02
`define ASRM_OFF_STATUS  8'h03
`define ASRM_OFF_KEY     8'h04
`define ASRM_OFF_CAUSE   8'h05
`define ASRM_OFF_XS      8'h06
`define ASRM_OFF_YS      8'h07
`define ASRM_OFF_ZS      8'h08
`define ASRM_OFF_MTHR    8'h09
`define ASRM_OFF_TMR     8'h0A
`define ASRM_OFF_FTHR    8'h0B
`define ASRM_OFF_SLAVE   8'h0C
`define ASRM_CTRL_RESET  8'h00
`define ASRM_BIT_RANGE   7
`define ASRM_BIT_POL     6
`define ASRM_BIT_STAY    5
`define ASRM_BIT_SLVOFF  4
`define ASRM_BIT_MODE_HI 3
`define ASRM_BIT_MODE_LO 1
`define ASRM_BIT_MASK    0
`define ASRM_BIT_PWRUP   3
`define ASRM_BIT_FAULT   0
`define ASRM_KEY_1       8'h02
`define ASRM_KEY_2       8'h0A
`define ASRM_KEY_3       8'h04
`define ASRM_MODE_PD0    3'h0
`define ASRM_MODE_M100   3'h1
`define ASRM_MODE_M400   3'h2
`define ASRM_MODE_M40    3'h3
`define ASRM_MODE_MD10   3'h4
`define ASRM_MODE_F100   3'h5
`define ASRM_MODE_F400   3'h6
`define ASRM_MASK_7BIT   8'h7F
`define ASRM_MASK_FTHR   8'h1F
`define ASRM_NVM_WORDS   6
`endif

// [rtl/asrm_pkg.sv]
// Types shared by the sensor register bank modules
package asrm_pkg;
   typedef enum {ASRM_PWR, ASRM_MEAS, ASRM_MOTION, ASRM_FALL} asrm_class_type;
   typedef enum {ASRM_LD_RUN, ASRM_LD_DONE} asrm_ld_type;
endpackage

// [rtl/asrm_nvm_if.sv]
// Link between register bank and non-volatile loader
`timescale 1ns/1ps
`default_nettype none
interface asrm_nvm_if;
   logic       restart;
   logic       valid;
   logic [2:0] idx;
   logic [7:0] data;
   logic       done;
   logic       fault;
   modport loader (input restart, output valid, idx, data, done, fault);
   modport user   (output restart, input valid, idx, data, done, fault);
endinterface
`default_nettype wire

// [rtl/asrm_nvm_loader.sv]
// Factory word loader with parity check
`timescale 1ns/1ps
`default_nettype none
`include "asrm_defines.svh"
module asrm_nvm_loader
   import asrm_pkg::*;
#(
   parameter logic [7:0] IDENT  = 8'h2A, // Arbitrary value
   parameter logic [7:0] REV    = 8'h10, // Arbitrary value
   parameter logic [7:0] SLAVE  = 8'h1C,
   parameter logic [7:0] MTHR   = 8'h08,
   parameter logic [7:0] TMR    = 8'h33,
   parameter logic [7:0] FTHR   = 8'h00,
   parameter logic       PARITY = ^{IDENT, REV, SLAVE, MTHR, TMR, FTHR}
) (
   input  wire logic  clk_i,
   input  wire logic  rstn_i,
   asrm_nvm_if.loader nvm
);
   logic [7:0]  rom [`ASRM_NVM_WORDS];
   asrm_ld_type st_q, st_d;
   logic [2:0]  idx_q, idx_d;
   logic        par_q, par_d;

   // Factory content, fixed at build time
   assign rom[0] = IDENT;
   assign rom[1] = REV;
   assign rom[2] = SLAVE;
   assign rom[3] = MTHR;
   assign rom[4] = TMR;
   assign rom[5] = FTHR;

   // One word per cycle, parity folded as it goes
   always_comb begin
      st_d  = st_q;
      idx_d = idx_q;
      par_d = par_q;
      if (nvm.restart) begin
         st_d  = ASRM_LD_RUN;
         idx_d = 3'h0;
         par_d = 1'b0; // Same start as after power-up, so a reload folds alike
      end else if (st_q == ASRM_LD_RUN) begin
         par_d = par_q ^ (^rom[idx_q]);
         if (idx_q == 3'(`ASRM_NVM_WORDS - 1)) begin
            st_d = ASRM_LD_DONE;
         end else begin
            idx_d = idx_q + 3'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q  <= ASRM_LD_RUN;
         idx_q <= 3'h0;
         par_q <= 1'b0;
      end else begin
         st_q  <= st_d;
         idx_q <= idx_d;
         par_q <= par_d;
      end
   end

   assign nvm.valid = (st_q == ASRM_LD_RUN) && !nvm.restart;
   assign nvm.idx   = idx_q;
   assign nvm.data  = rom[idx_q];
   assign nvm.done  = (st_q == ASRM_LD_DONE);
   assign nvm.fault = par_q ^ PARITY;
endmodule
`default_nettype wire

// [rtl/asrm_regbank.sv]
// Register bank of a three-axis acceleration sensor
// Operation
// - Control bit 7 picks range, 0 is 8 g, 1 is 2 g; resets to 0.
// - Control bit 6 sets irq pin polarity, 0 active high, 1 active low.
// - Control bit 5 clear: motion event jumps to 400 Hz measurement.
// - Control bit 4 set turns the serial slave off.
// - Mode field 3:1 decodes power down, measurement, motion and fall modes.
// - Control bit 0 set suppresses every interrupt assertion.
// - Status bit 3 is one after reset; any status read clears it.
// - Status bit 0 shows parity fault; status bits 7:4 and 2:1 read zero.
// - Writes 02h, 0Ah, 04h in a row to reset key reset the device.
// - Cause bit 2 set when free fall is seen.
// - Cause bits 1:0 give motion axis: none, X, Y, Z.
// - Any cause register read clears cause bits 2:0.
// - Addresses 00h to 0Ch are defined; 0Dh to 19h are reserved.
// - Identification is read-only, seven-bit code, bit 7 zero.
// - Revision is read-only, major in 7:4, minor in 3:0.
// - After reset factory values load from non-volatile store, not user alterable.
// - Loaded content is parity checked and the result shows in status.
// - Data ready interrupt drops when sample data is read.
// - Motion and fall interrupts hold until the cause register is read.
`timescale 1ns/1ps
`default_nettype none
`include "asrm_defines.svh"
module asrm_regbank
   import asrm_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       rstn_i,
   input  wire logic [7:0] addr_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       sample_valid_i,
   input  wire logic [7:0] x_i,
   input  wire logic [7:0] y_i,
   input  wire logic [7:0] z_i,
   input  wire logic       motion_i,
   input  wire logic [1:0] motion_axis_i,
   input  wire logic       fall_i,
   output logic      [7:0] rdata_o,
   output logic            irq_o,
   output logic            range_2g_o,
   output logic            serial_slave_off_o,
   output logic      [2:0] mode_o,
   output logic            soft_reset_o
);
   asrm_nvm_if nvm ();

   asrm_nvm_loader u_loader (
      .clk_i  (clk_i),
      .rstn_i (rstn_i),
      .nvm    (nvm)
   );

   // Mode field to operating class
   function automatic asrm_class_type mode_class(input logic [2:0] m);
      case (m)
         `ASRM_MODE_M100, `ASRM_MODE_M400, `ASRM_MODE_M40: mode_class = ASRM_MEAS;
         `ASRM_MODE_MD10: mode_class = ASRM_MOTION;
         `ASRM_MODE_F100, `ASRM_MODE_F400: mode_class = ASRM_FALL;
         default: mode_class = ASRM_PWR;
      endcase
   endfunction

   // Address match for a bus access
   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = (a == off);
   endfunction

   logic [7:0] ctrl_q, ctrl_d;
   logic       pwrup_q, pwrup_d;
   logic       fault_q, fault_d;
   logic [7:0] key_q, key_d;
   logic [1:0] stage_q, stage_d;
   logic       srst_q, srst_d;
   logic       fall_q, fall_d;
   logic [1:0] axis_q, axis_d;
   logic       drdy_q, drdy_d;
   logic [7:0] xs_q, xs_d, ys_q, ys_d, zs_q, zs_d;
   logic [7:0] mthr_q, mthr_d, tmr_q, tmr_d, fthr_q, fthr_d;
   logic [7:0] ident_q, ident_d, rev_q, rev_d, slave_q, slave_d;
   logic       ld_seen_q, ld_seen_d;
   logic [7:0] rdata_q, rdata_d;
   logic       irq_q, irq_d;

   asrm_class_type cls;
   logic           ev_motion, ev_fall, ev_sample;
   logic           rd_cause, rd_data, irq_active;

   assign cls       = mode_class(ctrl_q[`ASRM_BIT_MODE_HI:`ASRM_BIT_MODE_LO]);
   assign ev_motion = motion_i && (cls == ASRM_MOTION);
   assign ev_fall   = fall_i && (cls == ASRM_FALL);
   assign ev_sample = sample_valid_i && (cls != ASRM_PWR);
   assign rd_cause  = rd_i && hit(addr_i, `ASRM_OFF_CAUSE);
   assign rd_data   = rd_i && (hit(addr_i, `ASRM_OFF_XS) || hit(addr_i, `ASRM_OFF_YS)
                               || hit(addr_i, `ASRM_OFF_ZS));
   assign irq_active = drdy_q || fall_q || (axis_q != 2'h0);
   assign nvm.restart = srst_q;

   // Register state, events and software access
   always_comb begin
      ctrl_d    = ctrl_q;
      pwrup_d   = pwrup_q;
      fault_d   = fault_q;
      key_d     = key_q;
      stage_d   = stage_q;
      srst_d    = 1'b0;
      fall_d    = fall_q;
      axis_d    = axis_q;
      drdy_d    = drdy_q;
      xs_d      = xs_q;
      ys_d      = ys_q;
      zs_d      = zs_q;
      mthr_d    = mthr_q;
      tmr_d     = tmr_q;
      fthr_d    = fthr_q;
      ident_d   = ident_q;
      rev_d     = rev_q;
      slave_d   = slave_q;
      ld_seen_d = ld_seen_q;
      // Clear on read first, so events below win
      if (rd_i && hit(addr_i, `ASRM_OFF_STATUS)) begin
         pwrup_d = 1'b0;
      end
      if (rd_cause) begin
         fall_d = 1'b0;
         axis_d = 2'h0;
      end
      if (rd_data) begin
         drdy_d = 1'b0;
      end
      // Sample capture; power down keeps content
      if (ev_sample) begin
         xs_d = x_i;
         ys_d = y_i;
         zs_d = z_i;
         if (cls == ASRM_MEAS) begin
            drdy_d = 1'b1;
         end
      end
      if (ev_fall) begin
         fall_d = 1'b1;
      end
      if (ev_motion) begin
         axis_d = motion_axis_i;
         if (!ctrl_q[`ASRM_BIT_STAY]) begin
            ctrl_d[`ASRM_BIT_MODE_HI:`ASRM_BIT_MODE_LO] = `ASRM_MODE_M400;
         end
      end
      // Software writes; a host write beats the auto exit
      if (wr_i) begin
         if (!hit(addr_i, `ASRM_OFF_KEY)) begin
            stage_d = 2'h0;
         end
         case (addr_i)
            `ASRM_OFF_CTRL: ctrl_d = wdata_i;
            `ASRM_OFF_MTHR: mthr_d = wdata_i & `ASRM_MASK_7BIT;
            `ASRM_OFF_TMR:  tmr_d  = wdata_i;
            `ASRM_OFF_FTHR: fthr_d = wdata_i & `ASRM_MASK_FTHR;
            `ASRM_OFF_KEY: begin
               key_d = wdata_i;
               if (stage_q == 2'h2 && wdata_i == `ASRM_KEY_3) begin
                  srst_d  = 1'b1;
                  stage_d = 2'h0;
               end else if (stage_q == 2'h1 && wdata_i == `ASRM_KEY_2) begin
                  stage_d = 2'h2;
               end else if (wdata_i == `ASRM_KEY_1) begin
                  stage_d = 2'h1;
               end else begin
                  stage_d = 2'h0;
               end
            end
            default: ; // Read-only and reserved writes dropped
         endcase
      end
      // Factory words overwrite the volatile copies
      if (nvm.valid) begin
         case (nvm.idx)
            3'h0: ident_d = nvm.data & `ASRM_MASK_7BIT;
            3'h1: rev_d   = nvm.data;
            3'h2: slave_d = nvm.data & `ASRM_MASK_7BIT;
            3'h3: mthr_d  = nvm.data & `ASRM_MASK_7BIT;
            3'h4: tmr_d   = nvm.data;
            default: fthr_d = nvm.data & `ASRM_MASK_FTHR;
         endcase
      end
      if (nvm.done && !ld_seen_q) begin
         fault_d   = nvm.fault;
         ld_seen_d = 1'b1;
      end
      // Keyed reset returns control, status, key, cause and sample state to power-up values
      if (srst_q) begin
         ctrl_d    = `ASRM_CTRL_RESET;
         pwrup_d   = 1'b1;
         fault_d   = 1'b0;
         key_d     = 8'h00;
         stage_d   = 2'h0;
         fall_d    = 1'b0;
         axis_d    = 2'h0;
         drdy_d    = 1'b0;
         xs_d      = 8'h00;
         ys_d      = 8'h00;
         zs_d      = 8'h00;
         ld_seen_d = 1'b0;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctrl_q    <= `ASRM_CTRL_RESET;
         pwrup_q   <= 1'b1;
         fault_q   <= 1'b0;
         key_q     <= 8'h00;
         stage_q   <= 2'h0;
         srst_q    <= 1'b0;
         fall_q    <= 1'b0;
         axis_q    <= 2'h0;
         drdy_q    <= 1'b0;
         xs_q      <= 8'h00;
         ys_q      <= 8'h00;
         zs_q      <= 8'h00;
         mthr_q    <= 8'h00;
         tmr_q     <= 8'h00;
         fthr_q    <= 8'h00;
         ident_q   <= 8'h00;
         rev_q     <= 8'h00;
         slave_q   <= 8'h00;
         ld_seen_q <= 1'b0;
      end else begin
         ctrl_q    <= ctrl_d;
         pwrup_q   <= pwrup_d;
         fault_q   <= fault_d;
         key_q     <= key_d;
         stage_q   <= stage_d;
         srst_q    <= srst_d;
         fall_q    <= fall_d;
         axis_q    <= axis_d;
         drdy_q    <= drdy_d;
         xs_q      <= xs_d;
         ys_q      <= ys_d;
         zs_q      <= zs_d;
         mthr_q    <= mthr_d;
         tmr_q     <= tmr_d;
         fthr_q    <= fthr_d;
         ident_q   <= ident_d;
         rev_q     <= rev_d;
         slave_q   <= slave_d;
         ld_seen_q <= ld_seen_d;
      end
   end

   // Read mux and interrupt pin
   always_comb begin
      rdata_d = rdata_q;
      if (rd_i) begin
         case (addr_i)
            `ASRM_OFF_IDENT:  rdata_d = ident_q;
            `ASRM_OFF_REV:    rdata_d = rev_q;
            `ASRM_OFF_CTRL:   rdata_d = ctrl_q;
            `ASRM_OFF_STATUS: rdata_d = {4'h0, pwrup_q, 2'h0, fault_q};
            `ASRM_OFF_KEY:    rdata_d = key_q;
            `ASRM_OFF_CAUSE:  rdata_d = {5'h00, fall_q, axis_q};
            `ASRM_OFF_XS:     rdata_d = xs_q;
            `ASRM_OFF_YS:     rdata_d = ys_q;
            `ASRM_OFF_ZS:     rdata_d = zs_q;
            `ASRM_OFF_MTHR:   rdata_d = mthr_q;
            `ASRM_OFF_TMR:    rdata_d = tmr_q;
            `ASRM_OFF_FTHR:   rdata_d = fthr_q;
            `ASRM_OFF_SLAVE:  rdata_d = slave_q;
            default:          rdata_d = 8'h00;
         endcase
      end
      irq_d = ctrl_q[`ASRM_BIT_POL] ^ (irq_active && !ctrl_q[`ASRM_BIT_MASK]);
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_q <= 8'h00;
         irq_q   <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         irq_q   <= irq_d;
      end
   end

   assign rdata_o            = rdata_q;
   assign irq_o              = irq_q;
   assign range_2g_o         = ctrl_q[`ASRM_BIT_RANGE];
   assign serial_slave_off_o = ctrl_q[`ASRM_BIT_SLVOFF];
   assign mode_o             = ctrl_q[`ASRM_BIT_MODE_HI:`ASRM_BIT_MODE_LO];
   assign soft_reset_o       = srst_q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   irq_pin_a: assert property (
      ##1 irq_o == $past(ctrl_q[`ASRM_BIT_POL] ^ (irq_active && !ctrl_q[`ASRM_BIT_MASK])))
      else $error("irq pin level wrong");
   irq_mask_a: assert property (
      ctrl_q[`ASRM_BIT_MASK] && !wr_i && !srst_q |=> irq_o == ctrl_q[`ASRM_BIT_POL])
      else $error("masked irq asserted");
   motion_exit_a: assert property (
      ev_motion && !ctrl_q[`ASRM_BIT_STAY] && !wr_i && !srst_q |=> mode_o == `ASRM_MODE_M400)
      else $error("no exit to fast measurement");
   motion_stay_a: assert property (
      ev_motion && ctrl_q[`ASRM_BIT_STAY] && !wr_i && !srst_q |=> $stable(mode_o))
      else $error("mode changed while staying");
   pwrup_clr_a: assert property (
      rd_i && hit(addr_i, `ASRM_OFF_STATUS) && !srst_q
      |=> !pwrup_q && rdata_o[3] == $past(pwrup_q))
      else $error("power-up flag not cleared");
   key_seq_a: assert property (
      wr_i && hit(addr_i, `ASRM_OFF_KEY) && wdata_i == `ASRM_KEY_1 && !srst_q
      ##1 wr_i && hit(addr_i, `ASRM_OFF_KEY) && wdata_i == `ASRM_KEY_2
      ##1 wr_i && hit(addr_i, `ASRM_OFF_KEY) && wdata_i == `ASRM_KEY_3
      |=> soft_reset_o ##1 pwrup_q && ctrl_q == `ASRM_CTRL_RESET)
      else $error("key sequence did not reset");
   key_only_a: assert property (
      soft_reset_o |-> $past(wr_i && hit(addr_i, `ASRM_OFF_KEY) && wdata_i == `ASRM_KEY_3))
      else $error("reset without key");
   fall_set_a: assert property (
      ev_fall && !srst_q |=> fall_q)
      else $error("fall not recorded");
   axis_set_a: assert property (
      ev_motion && !srst_q |=> axis_q == $past(motion_axis_i))
      else $error("axis not recorded");
   cause_clr_a: assert property (
      rd_cause && !ev_fall && !ev_motion |=> !fall_q && axis_q == 2'h0)
      else $error("cause not cleared");
   drdy_clr_a: assert property (
      rd_data && !ev_sample |=> !drdy_q)
      else $error("data ready not cleared");
   reserved_rd_a: assert property (
      rd_i && addr_i > `ASRM_OFF_SLAVE |=> rdata_o == 8'h00)
      else $error("reserved read not zero");
   ident_rd_a: assert property (
      rd_i && hit(addr_i, `ASRM_OFF_IDENT) |=> !rdata_o[7])
      else $error("ident bit 7 set");
   status_rsv_a: assert property (
      rd_i && hit(addr_i, `ASRM_OFF_STATUS) |=> rdata_o[7:4] == 4'h0 && rdata_o[2:1] == 2'h0)
      else $error("status reserved bits set");
   parity_a: assert property (
      nvm.done && !ld_seen_q && !srst_q |=> fault_q == $past(nvm.fault))
      else $error("parity result not shown");
endmodule
`default_nettype wire

// [test/asrm_host_model.sv]
// Host controller model that drives the register bank byte bus
`timescale 1ns/1ps
`default_nettype none
`include "asrm_defines.svh"
module asrm_host_model #(
   parameter int SETTLE = 2
) (
   input  wire logic       clk_i,
   input  wire logic [7:0] rdata_i,
   output logic      [7:0] addr_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] wdata_o
);
   // Quiet bus at time zero
   initial begin
      addr_o  = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      wdata_o = 8'h00;
   end

   // One write strobe, then scrambled idle lines
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o  = a;
      wdata_o = d;
      wr_o    = 1'b1;
      @(posedge clk_i);
      #1;
      wr_o    = 1'b0;
      addr_o  = ~a;
      wdata_o = ~d;
      // Give the device time to reach a new mode
      if (a == `ASRM_OFF_CTRL) repeat (SETTLE) @(posedge clk_i);
   endtask

   // One read strobe; data is taken once it has landed
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_i);
      #1;
      addr_o = a;
      rd_o   = 1'b1;
      @(posedge clk_i);
      #1;
      rd_o   = 1'b0;
      addr_o = ~a;
      @(posedge clk_i);
      #1;
      d = rdata_i;
   endtask

   // Only the documented key order is ever sent, strobe held across all three
   task automatic key_reset();
      @(posedge clk_i);
      #1;
      addr_o  = `ASRM_OFF_KEY;
      wdata_o = `ASRM_KEY_1;
      wr_o    = 1'b1;
      @(posedge clk_i);
      #1;
      wdata_o = `ASRM_KEY_2;
      @(posedge clk_i);
      #1;
      wdata_o = `ASRM_KEY_3;
      @(posedge clk_i);
      #1;
      wr_o    = 1'b0;
      addr_o  = ~`ASRM_OFF_KEY;
      wdata_o = ~`ASRM_KEY_3;
   endtask
endmodule
`default_nettype wire

// [test/accel_sensor_register_map_tb.sv]
// Self-checking bench for the sensor register bank
`timescale 1ns/1ps
`default_nettype none
`include "asrm_defines.svh"
module accel_sensor_register_map_tb;
   localparam logic [7:0] ID_CODE  = 8'h2A; // Arbitrary value, loader default
   localparam logic [7:0] REV_CODE = 8'h10; // Arbitrary value, loader default
   logic        clk_i;
   logic        rstn_i;
   logic [7:0]  addr, wdata, rdata, x, y, z, ex, ey, ez, v, ctl, cause;
   logic        wr, rd, smp, motion, fall, irq, range_2g, slv_off, soft_rst, act, meas;
   logic [1:0]  axis, ax;
   logic [2:0]  mode;
   logic [31:0] seed;
   int          fail_count, n_checks, n_soft, n0;

   asrm_regbank i_asrm_regbank (
      .clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
      .wdata_i(wdata), .sample_valid_i(smp), .x_i(x), .y_i(y), .z_i(z),
      .motion_i(motion), .motion_axis_i(axis), .fall_i(fall), .rdata_o(rdata),
      .irq_o(irq), .range_2g_o(range_2g), .serial_slave_off_o(slv_off),
      .mode_o(mode), .soft_reset_o(soft_rst));

   asrm_host_model i_asrm_host_model (
      .clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata));

   // Clock source
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // Count keyed reset pulses
   always @(posedge clk_i) begin
      if (soft_rst === 1'b1) n_soft <= n_soft + 1;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic rnd(output logic [7:0] r);
      seed = lfsr(seed);
      r = seed[7:0];
   endtask

   // Expected readback after a write of d to address a
   function automatic logic [7:0] exp_wr(input logic [7:0] a, input logic [7:0] d);
      case (a)
         `ASRM_OFF_IDENT: return ID_CODE & `ASRM_MASK_7BIT;
         `ASRM_OFF_REV:   return REV_CODE;
         `ASRM_OFF_MTHR:  return d & `ASRM_MASK_7BIT;
         `ASRM_OFF_TMR:   return d;
         `ASRM_OFF_FTHR:  return d & `ASRM_MASK_FTHR;
         `ASRM_OFF_SLAVE: return 8'h1C;
         default:         return 8'h00;
      endcase
   endfunction

   task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask

   task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string name);
      logic [7:0] d;
      i_asrm_host_model.rd(a, d);
      chk(name, e, d);
   endtask

   // Sample, motion and fall events in one cycle, then time for the pin
   task automatic pulse(input logic [1:0] a);
      rnd(ex);
      rnd(ey);
      rnd(ez);
      @(posedge clk_i);
      #1;
      {smp, motion, fall, axis, x, y, z} = {3'b111, a, ex, ey, ez};
      @(posedge clk_i);
      #1;
      {smp, motion, fall, axis, x, y, z} = {3'b000, ~a, ~ex, ~ey, ~ez};
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Watchdog against a hang
   initial begin
      #400000;
      fail_count++;
      give_verdict();
   end

   initial begin
      seed = 32'h84F15FC1;
      {fail_count, n_checks, n_soft} = '0;
      {smp, motion, fall, axis, x, y, z} = '0;
      rstn_i = 1'b0;
      repeat (10) @(posedge clk_i);
      #1;
      chk("irq in reset", 8'h00, {7'h0, irq});
      rstn_i = 1'b1;
      repeat (8) @(posedge clk_i);
      rchk(`ASRM_OFF_CTRL, 8'h00, "control reset");
      chk("range reset", 8'h00, {7'h0, range_2g});
      rchk(`ASRM_OFF_STATUS, 8'h08, "status");
      rchk(`ASRM_OFF_STATUS, 8'h00, "status reread");
      rchk(`ASRM_OFF_IDENT, ID_CODE, "ident");
      rchk(`ASRM_OFF_REV, REV_CODE, "revision");
      rchk(`ASRM_OFF_MTHR, 8'h08, "motion thr");
      rchk(`ASRM_OFF_TMR, 8'h33, "timers");
      rchk(`ASRM_OFF_FTHR, 8'h00, "fall thr");
      rchk(`ASRM_OFF_SLAVE, 8'h1C, "slave addr");
      $display("test reset_values done");
      // Writes to read-only, reserved and masked places
      for (int a = 0; a < 8'h1A; a++) begin
         if (a == 2 || (a > 3 && a < 9)) continue;
         rnd(v);
         i_asrm_host_model.wr(a[7:0], v);
         rchk(a[7:0], exp_wr(a[7:0], v), "write readback");
      end
      $display("test address_map done");
      // Control register and its outputs, corners first
      for (int i = 0; i < 6; i++) begin
         if (i == 0) v = 8'hFF;
         else if (i == 1) v = 8'h00;
         else rnd(v);
         i_asrm_host_model.wr(`ASRM_OFF_CTRL, v);
         rchk(`ASRM_OFF_CTRL, v, "control rw");
         chk("range out", {7'h0, v[7]}, {7'h0, range_2g});
         chk("slave off", {7'h0, v[4]}, {7'h0, slv_off});
         chk("mode out", {5'h0, v[3:1]}, {5'h0, mode});
         chk("idle irq", {7'h0, v[6]}, {7'h0, irq});
      end
      $display("test control done");
      // Every mode with both polarities and a random mask
      for (int i = 0; i < 16; i++) begin
         rnd(v);
         ctl = {v[7], i[3], 1'b1, v[4], i[2:0], v[0]};
         i_asrm_host_model.wr(`ASRM_OFF_CTRL, ctl);
         ax = (v[2:1] == 2'b00) ? 2'b11 : v[2:1];
         pulse(ax);
         meas = (i[2:0] > 0 && i[2:0] < 4);
         cause = (i[2:0] == 4) ? {6'h0, ax} : ((i[2:0] == 5 || i[2:0] == 6) ? 8'h04 : 8'h00);
         act = meas | (cause != 8'h00);
         chk("irq event", {7'h0, i[3] ^ (act & ~v[0])}, {7'h0, irq});
         rchk(`ASRM_OFF_CAUSE, cause, "cause");
         rchk(`ASRM_OFF_CAUSE, 8'h00, "cause cleared");
         if (meas) begin
            chk("irq held", {7'h0, i[3] ^ ~v[0]}, {7'h0, irq});
            rchk(`ASRM_OFF_XS, ex, "x sample");
            rchk(`ASRM_OFF_YS, ey, "y sample");
            rchk(`ASRM_OFF_ZS, ez, "z sample");
         end
         chk("irq acked", {7'h0, i[3]}, {7'h0, irq});
      end
      $display("test modes done");
      // Motion with the stay bit clear leaves for 400 Hz measurement
      i_asrm_host_model.wr(`ASRM_OFF_CTRL, 8'h08);
      pulse(2'b01);
      chk("auto exit", 8'h02, {5'h0, mode});
      rchk(`ASRM_OFF_CTRL, 8'h04, "exit control");
      rchk(`ASRM_OFF_CAUSE, 8'h01, "exit cause");
      $display("test auto_exit done");
      // Broken key order, then the real one
      n0 = n_soft;
      i_asrm_host_model.wr(`ASRM_OFF_KEY, `ASRM_KEY_1);
      i_asrm_host_model.wr(`ASRM_OFF_KEY, `ASRM_KEY_2);
      i_asrm_host_model.wr(`ASRM_OFF_MTHR, 8'h11);
      i_asrm_host_model.wr(`ASRM_OFF_KEY, `ASRM_KEY_3);
      repeat (3) @(posedge clk_i);
      chk("no reset", n0[7:0], n_soft[7:0]);
      rchk(`ASRM_OFF_KEY, `ASRM_KEY_3, "key readback");
      i_asrm_host_model.wr(`ASRM_OFF_CTRL, 8'hC1);
      i_asrm_host_model.key_reset();
      repeat (10) @(posedge clk_i);
      chk("one reset", n0[7:0] + 8'h01, n_soft[7:0]);
      rchk(`ASRM_OFF_CTRL, 8'h00, "control after key");
      rchk(`ASRM_OFF_STATUS, 8'h08, "status after key");
      rchk(`ASRM_OFF_MTHR, 8'h08, "thr reloaded");
      $display("test key_reset done");
      give_verdict();
   end
endmodule
`default_nettype wire
